//--- common/crss_map.svh
// Register indices, field positions, reset values and timing for the run sequencer
`ifndef CRSS_MAP_SVH
`define CRSS_MAP_SVH
// Register indices; byte address is four times the index
`define CRSS_IDX_CMD      19'h00064
`define CRSS_IDX_STATUS   19'h0006E
`define CRSS_IDX_TIMEOUT  19'h480DA
`define CRSS_IDX_CONFIG   19'h00200
`define CRSS_IDX_PRELEN   19'h00201
`define CRSS_IDX_POSTLEN  19'h00202
`define CRSS_IDX_SEGS     19'h00203
`define CRSS_IDX_WAITST   19'h00204
// Command word bit positions
`define CRSS_CMD_LAUNCH   2
`define CRSS_CMD_ARM      3
`define CRSS_CMD_FORCE    4
`define CRSS_CMD_DISARM   5
`define CRSS_CMD_HALT     6
`define CRSS_CMD_WAIT_HI  14
`define CRSS_CMD_WAIT_LO  12
// Status word bit positions
`define CRSS_ST_PRE       0
`define CRSS_ST_TRIG      1
`define CRSS_ST_DONE      2
`define CRSS_ST_SEG       3
// Configuration bit positions
`define CRSS_CFG_GEN      0
`define CRSS_CFG_MULTI    1
// Wait result bit positions
`define CRSS_WS_PEND      0
`define CRSS_WS_OK        1
`define CRSS_WS_TMO       2
`define CRSS_WS_ABORT     3
// Reset values
`define CRSS_TMO_RST      32'h00000000
`define CRSS_LEN_RST      32'h00000010
`define CRSS_SEGS_RST     32'h00000001
// Timing
`define CRSS_MS_NS        1000000
`define CRSS_CLK_NS       4
`endif

//--- common/crss_pkg.sv
// Types shared by the run sequencer: bus carriers, run states, module state
package crss_pkg;
    // Run engine states
    typedef enum logic [2:0] {
        CRSS_IDLE   = 3'b000,   // No run in progress
        CRSS_PRE    = 3'b001,   // Filling pretrigger region
        CRSS_TRIGW  = 3'b010,   // Pretrigger full, looking for trigger
        CRSS_POST   = 3'b011,   // Acquiring post-trigger samples
        CRSS_GENW   = 3'b100,   // Generation armed and waiting
        CRSS_REPLAY = 3'b101    // Generation replaying data
    } crss_run_e;

    // Avalon-MM request from the master
    typedef struct packed {
        logic        read;        // Read strobe
        logic        write;       // Write strobe
        logic [20:0] address;     // Byte address
        logic [31:0] writedata;   // Write data
        logic [3:0]  byteenable;  // Byte lanes
    } crss_avs_req_s;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;    // Read data
        logic        waitrequest; // Stall until low
    } crss_avs_rsp_s;

    // Whole state of the sequencer
    typedef struct packed {
        crss_avs_rsp_s rsp;       // Bus answer
        logic [2:0]    trig_sync; // Trigger synchroniser and edge stage
        crss_run_e     run;       // Run state
        logic          armed;     // Trigger detection enabled
        logic          force_pend;// Forced trigger waiting to be applied
        logic [3:0]    status;    // Card status bits
        logic [31:0]   timeout;   // Wait limit in ms, zero disables
        logic [1:0]    config_r;  // Mode bits
        logic [31:0]   pre_len;   // Pretrigger samples
        logic [31:0]   post_len;  // Post-trigger or replay samples
        logic [31:0]   segs;      // Segments per run
        logic [31:0]   cnt;       // Sample counter
        logic [31:0]   seg_left;  // Segments still to acquire
        logic          wait_pend; // Wait command pending
        logic [2:0]    wait_mask; // Status bits awaited
        logic [3:1]    wait_res;  // Ok, timeout, abort
        logic          tmo_en;    // Pending wait is bounded
        logic [31:0]   tmo_cnt;   // Remaining milliseconds
        logic [31:0]   ms_cnt;    // Millisecond divider
        logic          acq_on;    // Acquisition active output
        logic          replay_on; // Replay active output
    } crss_state_s;
endpackage

//--- hdl/crss_top.sv
// Run-control sequencer with status word, command word and wait timeout
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "crss_map.svh"

// One Avalon-MM port reaches all registers
// Each access stalls one cycle; read data come from a flop
// Samples arrive as one-cycle strobes
// The trigger pin is asynchronous
module crss_top #(
    parameter int unsigned MS_CYCLES = `CRSS_MS_NS / `CRSS_CLK_NS  // Clock cycles per millisecond
) (
    input  wire logic                   core_clk,     // Card clock, 250 MHz
    input  wire logic                   rst_b,        // Asynchronous reset, active low
    input  wire crss_pkg::crss_avs_req_s avs_req,     // Avalon-MM request
    output      crss_pkg::crss_avs_rsp_s avs_rsp,     // Avalon-MM answer
    input  wire logic                   ext_trig,     // Trigger pin, asynchronous
    input  wire logic                   sample_stb,   // One-cycle pulse per sample
    output      logic                   acq_active,   // Acquisition in progress
    output      logic                   replay_active,// Replay output enabled
    output      logic                   wait_pending  // A wait command is pending
);
    import crss_pkg::*;

    // All state in one struct, one register
    crss_state_s q;              // Registered state
    crss_state_s d;              // Next state
    logic [18:0] idx;            // Word index of the access
    logic [31:0] wmask;          // Byte-lane mask of the write
    logic [31:0] wval;           // Masked write data
    logic        req;            // Read or write present
    logic        commit;         // Access completes this edge
    logic [31:0] cmd;            // Command word written this edge
    logic        trig_edge;      // Rising edge of the synchronised trigger
    logic        hit;            // Trigger accepted this cycle
    logic        last_sample;    // Counter reaches its end on this sample
    logic        ms_tick;        // One-millisecond tick
    logic [31:0] ms_last;        // Divider terminal value

    // Bus decode helpers
    // Lane mask lets partial writes merge
    // Divider end cut to counter width on purpose
    always_comb begin
        idx     = avs_req.address[20:2];
        req     = avs_req.read | avs_req.write;
        commit  = req & ~q.rsp.waitrequest;
        wmask   = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
                   {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
        wval    = avs_req.writedata & wmask;
        ms_last = 32'(MS_CYCLES - 1);
    end

    // Next-state logic for the whole block
    // Later sections override earlier ones:
    // halt beats progress, a new wait beats the old
    always_comb begin
        d = q;

        // Trigger pin synchroniser; edge taken from the second and third stages
        // Only the second and third stages feed logic
        // Reset level equals idle low: no false edge
        d.trig_sync = {q.trig_sync[1:0], ext_trig};
        trig_edge   = q.trig_sync[1] & ~q.trig_sync[2];

        // Waitrequest high by default, low for one cycle per access
        // Back-to-back accesses each pay the stall
        d.rsp.waitrequest = ~(req & q.rsp.waitrequest);

        // Read data prepared in the stall cycle, stands while waitrequest is low
        // Loading early keeps the read path short
        // Spare status bits read as zero
        if (req && q.rsp.waitrequest && avs_req.read) begin
            if (idx == `CRSS_IDX_STATUS) begin
                d.rsp.readdata = {28'h0000000, q.status};
            end else if (idx == `CRSS_IDX_TIMEOUT) begin
                d.rsp.readdata = q.timeout;
            end else if (idx == `CRSS_IDX_CONFIG) begin
                d.rsp.readdata = {30'h00000000, q.config_r};
            end else if (idx == `CRSS_IDX_PRELEN) begin
                d.rsp.readdata = q.pre_len;
            end else if (idx == `CRSS_IDX_POSTLEN) begin
                d.rsp.readdata = q.post_len;
            end else if (idx == `CRSS_IDX_SEGS) begin
                d.rsp.readdata = q.segs;
            end else if (idx == `CRSS_IDX_WAITST) begin
                d.rsp.readdata = {28'h0000000, q.wait_res, q.wait_pend};
            end else begin
                // Command word is write-only; unmapped reads return zero
                d.rsp.readdata = 32'h00000000;
            end
        end

        // Register writes take effect at the edge that completes the access
        // Never during the stall cycle
        // Command bits act for one cycle only
        // A pending wait keeps its old limit
        cmd = 32'h00000000;
        if (commit && avs_req.write) begin
            if (idx == `CRSS_IDX_CMD) begin
                cmd = wval;
            end else if (idx == `CRSS_IDX_TIMEOUT) begin
                // Zero disables, nonzero bounds later waits
                d.timeout = (q.timeout & ~wmask) | wval;
            end else if (idx == `CRSS_IDX_CONFIG) begin
                d.config_r = (q.config_r & ~wmask[1:0]) | wval[1:0];
            end else if (idx == `CRSS_IDX_PRELEN) begin
                d.pre_len = (q.pre_len & ~wmask) | wval;
            end else if (idx == `CRSS_IDX_POSTLEN) begin
                d.post_len = (q.post_len & ~wmask) | wval;
            end else if (idx == `CRSS_IDX_SEGS) begin
                d.segs = (q.segs & ~wmask) | wval;
            end
            // Status word and unmapped writes are ignored
        end

        // Trigger accepted when armed, forced now, or forced earlier
        // Only trigger-looking states read it
        // A pin edge in pretrigger is lost
        hit = (trig_edge & q.armed) | cmd[`CRSS_CMD_FORCE] | q.force_pend;
        last_sample = (q.cnt + 32'h00000001) >= ((q.run == CRSS_PRE) ? q.pre_len : q.post_len);

        // Run engine
        // Counters move only on sample strobes
        // Lengths below one act as one
        case (q.run)
            CRSS_IDLE: begin
                // Nothing to do until a launch
                // No stale force may reach the next run
                d.force_pend = 1'b0;
            end
            CRSS_PRE: begin
                // Triggers are not looked at until the region is full
                // A force is held for the trigger search
                if (cmd[`CRSS_CMD_FORCE]) begin
                    d.force_pend = 1'b1;
                end
                if (sample_stb) begin
                    if (last_sample) begin
                        // Only the first segment sets the run flag
                        if (q.seg_left == q.segs) begin
                            d.status[`CRSS_ST_PRE] = 1'b1;
                        end
                        // Segment flag on every segment fill in multi mode
                        if (q.config_r[`CRSS_CFG_MULTI]) begin
                            d.status[`CRSS_ST_SEG] = 1'b1;
                        end
                        d.cnt = 32'h00000000;
                        d.run = CRSS_TRIGW;
                    end else begin
                        d.cnt = q.cnt + 32'h00000001;
                    end
                end
            end
            CRSS_TRIGW: begin
                // Looking for a trigger
                // Forced and pin triggers act alike
                if (hit) begin
                    d.status[`CRSS_ST_TRIG] = 1'b1;
                    d.force_pend = 1'b0;
                    d.cnt = 32'h00000000;
                    d.run = CRSS_POST;
                end
            end
            CRSS_POST: begin
                // Post-trigger acquisition, then next segment or done
                // Multi runs refill the next pretrigger
                // The last segment ends the run
                if (sample_stb) begin
                    if (last_sample) begin
                        d.cnt = 32'h00000000;
                        if (q.config_r[`CRSS_CFG_MULTI] && q.seg_left > 32'h00000001) begin
                            d.seg_left = q.seg_left - 32'h00000001;
                            d.run = CRSS_PRE;
                        end else begin
                            d.status[`CRSS_ST_DONE] = 1'b1;
                            d.run = CRSS_IDLE;
                        end
                    end else begin
                        d.cnt = q.cnt + 32'h00000001;
                    end
                end
            end
            CRSS_GENW: begin
                // Armed and waiting, output stays off
                // No sample counting while waiting
                if (hit) begin
                    d.status[`CRSS_ST_TRIG] = 1'b1;
                    d.force_pend = 1'b0;
                    d.cnt = 32'h00000000;
                    d.run = CRSS_REPLAY;
                end
            end
            CRSS_REPLAY: begin
                // Replay the programmed length, then stop output
                // Done and output off share one edge
                if (sample_stb) begin
                    if (last_sample) begin
                        d.status[`CRSS_ST_DONE] = 1'b1;
                        d.cnt = 32'h00000000;
                        d.run = CRSS_IDLE;
                    end else begin
                        d.cnt = q.cnt + 32'h00000001;
                    end
                end
            end
            default: begin
                // Unused codes fall back to idle
                d.run = CRSS_IDLE;
            end
        endcase

        // Arm and disarm; arm wins when both are given
        // Arming lasts until disarm or launch
        if (cmd[`CRSS_CMD_DISARM]) begin
            d.armed = 1'b0;
        end
        if (cmd[`CRSS_CMD_ARM]) begin
            d.armed = 1'b1;
        end

        // Halt ends a running run and aborts a pending wait
        // Halt beats launch while running
        // Status bits survive a halt
        if (cmd[`CRSS_CMD_HALT] && q.run != CRSS_IDLE) begin
            d.run = CRSS_IDLE;
            d.cnt = 32'h00000000;
            d.force_pend = 1'b0;
        end else if (cmd[`CRSS_CMD_LAUNCH] && q.run == CRSS_IDLE) begin
            // Launch: clear flags, start disarmed unless arming in the same word
            // Segment countdown starts from the programmed count
            d.status     = 4'h0;
            d.armed      = cmd[`CRSS_CMD_ARM];
            d.force_pend = cmd[`CRSS_CMD_FORCE];
            d.cnt        = 32'h00000000;
            d.seg_left   = q.segs;
            d.run        = q.config_r[`CRSS_CFG_GEN] ? CRSS_GENW : CRSS_PRE;
        end

        // Millisecond divider runs only while a bounded wait pends
        // Restarted per wait: first tick a full ms later
        // An unbounded wait leaves the divider idle
        ms_tick = 1'b0;
        if (q.wait_pend && q.tmo_en) begin
            if (q.ms_cnt >= ms_last) begin
                d.ms_cnt = 32'h00000000;
                ms_tick  = 1'b1;
            end else begin
                d.ms_cnt = q.ms_cnt + 32'h00000001;
            end
        end

        // Pending wait: completion beats timeout; expiry touches nothing else
        // A timed-out run goes on to completion
        // Giving up needs a halt from the host
        // The segment bit is never awaited
        if (q.wait_pend) begin
            if (|(q.status[2:0] & q.wait_mask)) begin
                d.wait_pend = 1'b0;
                d.wait_res[`CRSS_WS_OK] = 1'b1;
            end else if (ms_tick) begin
                if (q.tmo_cnt <= 32'h00000001) begin
                    d.wait_pend = 1'b0;
                    d.wait_res[`CRSS_WS_TMO] = 1'b1;
                end else begin
                    d.tmo_cnt = q.tmo_cnt - 32'h00000001;
                end
            end
            // Without a bound the wait simply stays pending
        end

        // Halt aborts a pending wait
        // Nothing else changes beyond the halt itself
        if (cmd[`CRSS_CMD_HALT] && q.wait_pend) begin
            d.wait_pend = 1'b0;
            d.wait_res[`CRSS_WS_ABORT] = 1'b1;
        end

        // New wait command restarts the timeout from the programmed value
        // A zero limit leaves this wait unbounded
        // Results of the previous wait are cleared
        // Mask bits 2:0 map onto status bits 2:0
        if (|cmd[`CRSS_CMD_WAIT_HI:`CRSS_CMD_WAIT_LO]) begin
            d.wait_pend = 1'b1;
            d.wait_mask = cmd[`CRSS_CMD_WAIT_HI:`CRSS_CMD_WAIT_LO];
            d.wait_res  = 3'b000;
            d.tmo_cnt   = q.timeout;
            d.tmo_en    = (q.timeout != 32'h00000000);
            d.ms_cnt    = 32'h00000000;
        end

        // Registered outputs follow the next run state
        // So the pins match the run state
        d.acq_on    = (d.run == CRSS_PRE) || (d.run == CRSS_TRIGW) || (d.run == CRSS_POST);
        d.replay_on = (d.run == CRSS_REPLAY);
    end

    // State register
    // Reset keeps waitrequest high and timeout off
    // and the lengths at their defaults
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q                 <= '0;
            q.rsp.waitrequest <= 1'b1;
            q.run             <= CRSS_IDLE;
            q.status          <= 4'h0;
            q.timeout         <= `CRSS_TMO_RST;
            q.pre_len         <= `CRSS_LEN_RST;
            q.post_len        <= `CRSS_LEN_RST;
            q.segs            <= `CRSS_SEGS_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flip-flops
    // No logic between flops and pins
    assign avs_rsp       = q.rsp;
    assign acq_active    = q.acq_on;
    assign replay_active = q.replay_on;
    assign wait_pending  = q.wait_pend;
endmodule

//--- tb/crss_assertions.sv
// Port-level checks on the run sequencer
`timescale 1ns/1ps
`include "crss_map.svh"
module crss_assertions
    import crss_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 4  // Clock cycles per millisecond
) (
    input wire logic                    core_clk,      // Card clock
    input wire logic                    rst_b,         // Reset, active low
    input wire crss_pkg::crss_avs_req_s avs_req,       // Bus request
    input wire crss_pkg::crss_avs_rsp_s avs_rsp,       // Bus answer
    input wire logic                    ext_trig,      // Trigger pin
    input wire logic                    sample_stb,    // Sample pulse
    input wire logic                    acq_active,    // Acquiring
    input wire logic                    replay_active, // Replaying
    input wire logic                    wait_pending   // Wait pending
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Request seen while still stalled
    sequence s_req;
        (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
    endsequence
    // Read completing at this edge
    sequence s_rd;
        avs_req.read && !avs_rsp.waitrequest;
    endsequence
    AST_ONE_STALL: assert property (s_req |-> ##[1:2] !avs_rsp.waitrequest)
        else $error("bus request left unanswered");
    AST_LOW_ONE: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_CMD_RD0: assert property (s_rd ##0 avs_req.address[20:2] == `CRSS_IDX_CMD
        |-> avs_rsp.readdata == 32'h00000000) else $error("command word read not zero");
    AST_STAT_HI0: assert property (s_rd ##0 avs_req.address[20:2] == `CRSS_IDX_STATUS
        |-> avs_rsp.readdata[31:4] == 28'h0000000) else $error("status spare bits set");
    AST_EXCL: assert property (!(acq_active && replay_active))
        else $error("acquire and replay together");
    AST_ACQ_HOLD: assert property (acq_active && !sample_stb && !avs_req.write
        |=> acq_active) else $error("acquisition ended without a sample");
    AST_ACQ_RISE: assert property ($rose(acq_active) |-> $past(avs_req.write))
        else $error("acquisition started without a command");
    AST_REPLAY_END: assert property ($fell(replay_active)
        |-> $past(sample_stb) || $past(avs_req.write)) else $error("replay ended early");
    AST_WAIT_RISE: assert property ($rose(wait_pending) |-> $past(avs_req.write))
        else $error("wait pending without a command");
endmodule
bind crss_top crss_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .ext_trig(ext_trig), .sample_stb(sample_stb), .acq_active(acq_active),
    .replay_active(replay_active), .wait_pending(wait_pending));

//--- tb/crss_host_model.sv
// Host driver model: Avalon-MM master issuing register accesses
`timescale 1ns/1ps
module crss_host_model
    import crss_pkg::*;
(
    input  wire logic                    core_clk, // Card clock
    output      crss_pkg::crss_avs_req_s avs_req,  // Request to the card
    input  wire crss_pkg::crss_avs_rsp_s avs_rsp   // Answer from the card
);
    // Bus idle at time zero
    initial avs_req = '0;
    // One access, held until waitrequest low is sampled
    task automatic xfer(input logic wr, input logic [18:0] idx, input logic [31:0] wd,
                        output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: wd,
                     byteenable: 4'hF};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
        rdat = avs_rsp.readdata;
        // Release; stale data is inverted so nothing leans on it
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        avs_req.writedata <= ~wd;
        if (avs_rsp.waitrequest !== 1'b0) begin
            test_card_run_status_sequencer.error_cnt++;
            test_card_run_status_sequencer.summarize();
        end
    endtask
endmodule

//--- tb/test_card_run_status_sequencer.sv
// Self-checking bench for the run sequencer
`timescale 1ns/1ps
`include "crss_map.svh"
module test_card_run_status_sequencer;
    import crss_pkg::*;
    localparam logic [18:0] CMD = `CRSS_IDX_CMD;     // Command word
    localparam logic [18:0] STA = `CRSS_IDX_STATUS;  // Status word
    localparam logic [18:0] TMO = `CRSS_IDX_TIMEOUT; // Wait limit
    localparam logic [18:0] CFG = `CRSS_IDX_CONFIG;  // Mode bits
    localparam logic [18:0] PRE = `CRSS_IDX_PRELEN;  // Pretrigger length
    localparam logic [18:0] PST = `CRSS_IDX_POSTLEN; // Post length
    localparam logic [18:0] SEG = `CRSS_IDX_SEGS;    // Segment count
    localparam logic [18:0] WST = `CRSS_IDX_WAITST;  // Wait result
    logic          core_clk      = 1'b0; // Card clock
    logic          rst_b         = 1'b0; // Reset, active low
    logic          ext_trig      = 1'b0; // Trigger pin
    logic          sample_stb    = 1'b0; // Sample pulse
    crss_avs_req_s avs_req;              // Bus request
    crss_avs_rsp_s avs_rsp;              // Bus answer
    logic          acq_active;           // Acquiring
    logic          replay_active;        // Replaying
    logic          wait_pending;         // Wait pending
    int            error_cnt     = 0;    // Mismatches
    int            n_tests       = 0;    // Comparisons
    int            n;                    // Measured cycles
    // 250 MHz clock
    always #2 core_clk = ~core_clk;
    crss_top #(.MS_CYCLES(4)) DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_req(avs_req),
        .avs_rsp(avs_rsp), .ext_trig(ext_trig), .sample_stb(sample_stb),
        .acq_active(acq_active), .replay_active(replay_active), .wait_pending(wait_pending));
    crss_host_model HOST (.core_clk(core_clk), .avs_req(avs_req), .avs_rsp(avs_rsp));
    // Word comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    // Flag comparison, sampled mid-cycle
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [18:0] idx, input logic [31:0] d);
        logic [31:0] r;
        HOST.xfer(1'b1, idx, d, r);
    endtask
    task automatic rd_chk(input logic [18:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        HOST.xfer(1'b0, idx, 32'h00000000, r);
        chk(r, exp);
    endtask
    // Flag check after the edge has settled
    task automatic flag(input logic exp, input int sel);
        @(negedge core_clk);
        chk_bit(sel == 0 ? acq_active : sel == 1 ? replay_active : wait_pending, exp);
    endtask
    task automatic samp(input int k);
        repeat (k) begin
            @(posedge core_clk) sample_stb <= 1'b1;
            @(posedge core_clk) sample_stb <= 1'b0;
        end
    endtask
    task automatic trig();
        @(posedge core_clk) ext_trig <= 1'b1;
        repeat (3) @(posedge core_clk);
        ext_trig <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    // Cycles until the pending wait ends, bounded
    task automatic drop();
        n = 0;
        @(negedge core_clk);                 // Let the accepting edge settle first
        while (wait_pending === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic t_reset();
        rd_chk(TMO, 32'h00000000);
        rd_chk(STA, 32'h00000000);
        wr(STA, 32'h0000000F);
        rd_chk(STA, 32'h00000000);
        rd_chk(CMD, 32'h00000000);
        rd_chk(19'h00300, 32'h00000000);
    endtask
    task automatic t_acq();
        wr(CFG, 32'h0); wr(PRE, 32'h3); wr(PST, 32'h2);
        wr(CMD, 32'h00000004);
        samp(2);
        rd_chk(STA, 32'h00000000);
        samp(1);
        rd_chk(STA, 32'h00000001);
        trig();
        rd_chk(STA, 32'h00000001);
        wr(CMD, 32'h00000008);
        trig();
        rd_chk(STA, 32'h00000003);
        samp(1);
        flag(1'b1, 0);
        samp(1);
        rd_chk(STA, 32'h00000007);
        flag(1'b0, 0);
    endtask
    task automatic t_multi();
        wr(CFG, 32'h2); wr(SEG, 32'h2); wr(PRE, 32'h1); wr(PST, 32'h1);
        wr(CMD, 32'h0000000C);
        samp(1);
        rd_chk(STA, 32'h00000009);
        wr(CMD, 32'h00000010);
        rd_chk(STA, 32'h0000000B);
        samp(2);
        wr(CMD, 32'h00000010);
        samp(1);
        rd_chk(STA, 32'h0000000F);
        wr(CMD, 32'h00000004);
        rd_chk(STA, 32'h00000000);
        wr(CMD, 32'h00000040);
        flag(1'b0, 0);
    endtask
    task automatic t_gen();
        wr(CFG, 32'h1); wr(PST, 32'h2);
        wr(CMD, 32'h00000004);
        samp(3);
        flag(1'b0, 1);
        rd_chk(STA, 32'h00000000);
        wr(CMD, 32'h00000008);
        trig();
        rd_chk(STA, 32'h00000002);
        flag(1'b1, 1);
        samp(2);
        rd_chk(STA, 32'h00000006);
        flag(1'b0, 1);
    endtask
    task automatic t_wait();
        wr(CFG, 32'h0); wr(PRE, 32'h1); wr(TMO, 32'h3);
        rd_chk(TMO, 32'h00000003);
        wr(CMD, 32'h00000004);
        samp(1);
        repeat (2) begin
            wr(CMD, 32'h00002000);
            drop();
            chk_bit(n >= 11 && n <= 14, 1'b1);
            rd_chk(WST, 32'h00000004);
        end
        rd_chk(STA, 32'h00000001);
        flag(1'b1, 0);
        wr(TMO, 32'h0);
        wr(CMD, 32'h00002000);
        drop();
        flag(1'b1, 2);
        wr(CMD, 32'h00000040);
        flag(1'b0, 2);
        rd_chk(WST, 32'h00000008);
        rd_chk(STA, 32'h00000001);
        wr(PST, 32'h1);
        wr(CMD, 32'h0000001C);
        wr(CMD, 32'h00004000);
        flag(1'b1, 2);
        samp(2);
        @(posedge core_clk);                 // Wait ends one cycle after done
        flag(1'b0, 2);
        rd_chk(WST, 32'h00000002);
        rd_chk(STA, 32'h00000007);
    endtask
    // Print counts and verdict, then stop
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_acq();
        t_multi();
        t_gen();
        t_wait();
        summarize();
    end
endmodule
